// file: src/wfc_pkg.sv
// Constants and carrier types for the wake filter control and status bank.
// Assumes the management page holding the wake space is already selected.
package wfc_pkg;

    // =========================================
    // Management register numbers
    localparam logic [4:0] WFC_MGMT_ADDR_SET = 5'h11;
    localparam logic [4:0] WFC_MGMT_DATA = 5'h12;

    // =========================================
    // Wake space register indices
    localparam logic [15:0] WFC_IDX_WAKE_CTRL = 16'h0001;
    localparam logic [15:0] WFC_IDX_FILTER_EN = 16'h0002;
    localparam logic [15:0] WFC_IDX_STATUS = 16'h0003;
    localparam logic [15:0] WFC_IDX_ADDR_BASE = 16'h0010;
    localparam int WFC_ADDR_STRIDE = 4;
    localparam int WFC_NUM_ENTRIES = 7;
    localparam logic [15:0] WFC_IDX_ADDR_END = 16'h002C;

    // =========================================
    // Field positions
    localparam int WFC_EN_FLEX4 = 9;
    localparam int WFC_EN_FLEX5 = 10;
    localparam int WFC_EN_IGNORE_MGMT = 11;
    localparam int WFC_EN_FLEX0 = 12;
    localparam int WFC_EN_RESERVED = 8;
    localparam int WFC_CTRL_POWER_EVENT = 2;
    localparam int WFC_CTRL_FLEX6 = 14;
    localparam int WFC_CTRL_FLEX7 = 15;
    localparam int WFC_ST_EXACT = 2;
    localparam int WFC_ST_MCAST = 3;
    localparam int WFC_ST_FLEX4 = 8;
    localparam int WFC_ST_FLEX0 = 12;
    localparam int WFC_HIGH_VALID_BIT = 15;

    // =========================================
    // Reset values and masks
    localparam logic [15:0] WFC_FILTER_EN_RST = 16'h0000;
    localparam logic [15:0] WFC_FILTER_EN_WMASK = 16'hFEFF;
    localparam logic [15:0] WFC_STATUS_RST = 16'h0000;
    localparam logic [31:0] WFC_ADDR_LOW_RST = 32'h0000_0000;
    localparam logic [15:0] WFC_ZERO16 = 16'h0000;

    // =========================================
    // Nonvolatile words for entry 0
    localparam logic [1:0] WFC_NVM_WORD_LOW = 2'h0;
    localparam logic [1:0] WFC_NVM_WORD_MID = 2'h1;
    localparam logic [1:0] WFC_NVM_WORD_HIGH = 2'h2;

    // =========================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] regaddr;
        logic [15:0] wdata;
    } wfc_mgmt_req_t;

    typedef struct packed {
        logic valid;
        logic mgmt_pass;
        logic mcast_hash_hit;
        logic [15:0] hits;
        logic [47:0] dest_addr;
    } wfc_pkt_t;

    typedef struct packed {
        logic valid;
        logic [1:0] word_addr;
        logic [15:0] data;
    } wfc_nvm_word_t;

endpackage

// file: src/wfc_wake_regs.sv
// Wake filter enable, wake status, wake control flag and exact address entries.
// Assumes page selection and the serial management framing happen upstream;
// filter datapath delivers one packet verdict per strobe on ref_clk_in.
`timescale 1ns/1ps
`default_nettype none

module wfc_wake_regs (
    // Clock and resets
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic por_rst_in,
    // Management register access
    input wire wfc_pkg::wfc_mgmt_req_t mgmt_req_in,
    output logic [15:0] mgmt_rdata_out,
    output logic mgmt_rdata_valid_out,
    // Packet verdicts from the filter datapath
    input wire wfc_pkg::wfc_pkt_t pkt_in,
    // Nonvolatile load of entry 0
    input wire wfc_pkg::wfc_nvm_word_t nvm_in,
    // Wake outputs
    output logic wake_event_out,
    output logic [15:0] filter_enable_out
);
    import wfc_pkg::*;

    // =========================================
    // State
    logic [15:0] addr_ptr, next_addr_ptr;
    logic [15:0] rdata, next_rdata;
    logic rdata_valid, next_rdata_valid;
    logic [15:0] wake_filter_enable, next_wake_filter_enable;
    logic [15:0] wake_event_status, next_wake_event_status;
    logic power_event_flag, next_power_event_flag;
    logic flex6_en, next_flex6_en;
    logic flex7_en, next_flex7_en;
    logic wake_event, next_wake_event;
    logic [31:0] exact_address_low [WFC_NUM_ENTRIES];
    logic [31:0] next_exact_address_low [WFC_NUM_ENTRIES];
    logic [15:0] exact_address_high [WFC_NUM_ENTRIES];
    logic [15:0] next_exact_address_high [WFC_NUM_ENTRIES];
    logic address_entry_valid [WFC_NUM_ENTRIES];
    logic next_address_entry_valid [WFC_NUM_ENTRIES];

    // =========================================
    // Decode of the indirect access
    logic data_wr, data_rd, in_addr_space;
    logic [15:0] addr_off;
    logic [2:0] entry_sel;
    logic [1:0] word_sel;

    assign data_wr = mgmt_req_in.wr && (mgmt_req_in.regaddr == WFC_MGMT_DATA);
    assign data_rd = mgmt_req_in.rd && (mgmt_req_in.regaddr == WFC_MGMT_DATA);
    assign in_addr_space = (addr_ptr >= WFC_IDX_ADDR_BASE) && (addr_ptr < WFC_IDX_ADDR_END);
    assign addr_off = addr_ptr - WFC_IDX_ADDR_BASE;
    assign entry_sel = addr_off[4:2];
    assign word_sel = addr_off[1:0];

    // =========================================
    // Exact destination compare, one per entry
    logic [WFC_NUM_ENTRIES-1:0] exact_match;
    genvar gi;
    generate
        for (gi = 0; gi < WFC_NUM_ENTRIES; gi++) begin : g_entry
            assign exact_match[gi] = address_entry_valid[gi] &&
                (pkt_in.dest_addr == {exact_address_high[gi], exact_address_low[gi]});
        end
    endgenerate

    // =========================================
    // Hit qualification
    logic [15:0] enable_by_status;
    logic [15:0] raw_hits;
    logic [15:0] qualified_hits;

    always_comb begin
        enable_by_status[7:0] = wake_filter_enable[7:0];
        enable_by_status[WFC_ST_FLEX4] = wake_filter_enable[WFC_EN_FLEX4];
        enable_by_status[WFC_ST_FLEX4+1] = wake_filter_enable[WFC_EN_FLEX5];
        enable_by_status[WFC_ST_FLEX4+2] = flex6_en;
        enable_by_status[WFC_ST_FLEX4+3] = flex7_en;
        enable_by_status[15:WFC_ST_FLEX0] = wake_filter_enable[15:WFC_EN_FLEX0];
        raw_hits = pkt_in.hits;
        raw_hits[WFC_ST_EXACT] = pkt_in.hits[WFC_ST_EXACT] | (|exact_match);
        raw_hits[WFC_ST_MCAST] = pkt_in.hits[WFC_ST_MCAST] | pkt_in.mcast_hash_hit;
        qualified_hits = WFC_ZERO16;
        // With the ignore-manageability enable set, manageability traffic is dropped whole: neither recorded nor waking
        if (pkt_in.valid && !(pkt_in.mgmt_pass && wake_filter_enable[WFC_EN_IGNORE_MGMT])) begin
            qualified_hits = raw_hits & enable_by_status;
        end
    end

    // =========================================
    // Next state
    always_comb begin
        next_addr_ptr = addr_ptr;
        next_rdata = rdata;
        next_rdata_valid = 1'b0;
        next_wake_filter_enable = wake_filter_enable;
        next_wake_event_status = wake_event_status;
        next_power_event_flag = power_event_flag;
        next_flex6_en = flex6_en;
        next_flex7_en = flex7_en;
        next_wake_event = |qualified_hits;
        for (int i = 0; i < WFC_NUM_ENTRIES; i++) begin
            next_exact_address_low[i] = exact_address_low[i];
            next_exact_address_high[i] = exact_address_high[i];
            next_address_entry_valid[i] = address_entry_valid[i];
        end

        if (mgmt_req_in.wr && (mgmt_req_in.regaddr == WFC_MGMT_ADDR_SET)) begin
            next_addr_ptr = mgmt_req_in.wdata;
        end

        // Software clear first, hardware set after it so a same-cycle event survives
        if (data_wr) begin
            case (addr_ptr)
                WFC_IDX_WAKE_CTRL: begin
                    if (mgmt_req_in.wdata[WFC_CTRL_POWER_EVENT]) begin
                        next_power_event_flag = 1'b0;
                    end
                    next_flex6_en = mgmt_req_in.wdata[WFC_CTRL_FLEX6];
                    next_flex7_en = mgmt_req_in.wdata[WFC_CTRL_FLEX7];
                end
                WFC_IDX_FILTER_EN: begin
                    next_wake_filter_enable = mgmt_req_in.wdata & WFC_FILTER_EN_WMASK;
                end
                WFC_IDX_STATUS: begin
                    next_wake_event_status = wake_event_status & ~mgmt_req_in.wdata;
                end
                default: begin
                    if (in_addr_space) begin
                        case (word_sel)
                            2'd0: next_exact_address_low[entry_sel][15:0] = mgmt_req_in.wdata;
                            2'd1: next_exact_address_low[entry_sel][31:16] = mgmt_req_in.wdata;
                            2'd2: next_exact_address_high[entry_sel] = mgmt_req_in.wdata;
                            default: next_address_entry_valid[entry_sel] =
                                mgmt_req_in.wdata[WFC_HIGH_VALID_BIT];
                        endcase
                    end
                end
            endcase
        end

        // Entry 0 loads from nonvolatile memory; a management write in the same cycle loses
        if (nvm_in.valid) begin
            case (nvm_in.word_addr)
                WFC_NVM_WORD_LOW: next_exact_address_low[0][15:0] = nvm_in.data;
                WFC_NVM_WORD_MID: next_exact_address_low[0][31:16] = nvm_in.data;
                WFC_NVM_WORD_HIGH: next_exact_address_high[0] = nvm_in.data;
                default: next_exact_address_high[0] = exact_address_high[0];
            endcase
        end

        next_wake_event_status = next_wake_event_status | qualified_hits;
        if (|qualified_hits) begin
            next_power_event_flag = 1'b1;
        end

        if (data_rd) begin
            next_rdata_valid = 1'b1;
            case (addr_ptr)
                WFC_IDX_WAKE_CTRL: begin
                    next_rdata = WFC_ZERO16;
                    next_rdata[WFC_CTRL_POWER_EVENT] = power_event_flag;
                    next_rdata[WFC_CTRL_FLEX6] = flex6_en;
                    next_rdata[WFC_CTRL_FLEX7] = flex7_en;
                end
                WFC_IDX_FILTER_EN: next_rdata = wake_filter_enable;
                WFC_IDX_STATUS: next_rdata = wake_event_status;
                default: begin
                    next_rdata = WFC_ZERO16;
                    if (in_addr_space) begin
                        case (word_sel)
                            2'd0: next_rdata = exact_address_low[entry_sel][15:0];
                            2'd1: next_rdata = exact_address_low[entry_sel][31:16];
                            2'd2: next_rdata = exact_address_high[entry_sel];
                            default: next_rdata[WFC_HIGH_VALID_BIT] = address_entry_valid[entry_sel];
                        endcase
                    end
                end
            endcase
        end else if (mgmt_req_in.rd && (mgmt_req_in.regaddr == WFC_MGMT_ADDR_SET)) begin
            next_rdata_valid = 1'b1;
            next_rdata = addr_ptr;
        end else if (mgmt_req_in.rd) begin
            // Other management registers live elsewhere; answer zero
            next_rdata_valid = 1'b1;
            next_rdata = WFC_ZERO16;
        end
    end

    // =========================================
    // Access path state: cleared by PHY reset and power-on reset
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || por_rst_in) begin
            addr_ptr <= WFC_ZERO16;
            rdata <= WFC_ZERO16;
            rdata_valid <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            addr_ptr <= next_addr_ptr;
            rdata <= next_rdata;
            rdata_valid <= next_rdata_valid;
            wake_event <= next_wake_event;
        end
    end

    // =========================================
    // Wake registers: PHY reset does not touch them, only power-on reset
    always_ff @(posedge ref_clk_in) begin
        if (por_rst_in) begin
            wake_filter_enable <= WFC_FILTER_EN_RST;
            wake_event_status <= WFC_STATUS_RST;
            power_event_flag <= 1'b0;
            flex6_en <= 1'b0;
            flex7_en <= 1'b0;
            for (int i = 0; i < WFC_NUM_ENTRIES; i++) begin
                exact_address_low[i] <= WFC_ADDR_LOW_RST;
                exact_address_high[i] <= WFC_ZERO16;
                address_entry_valid[i] <= 1'b0;
            end
        end else begin
            wake_filter_enable <= next_wake_filter_enable;
            wake_event_status <= next_wake_event_status;
            power_event_flag <= next_power_event_flag;
            flex6_en <= next_flex6_en;
            flex7_en <= next_flex7_en;
            for (int i = 0; i < WFC_NUM_ENTRIES; i++) begin
                exact_address_low[i] <= next_exact_address_low[i];
                exact_address_high[i] <= next_exact_address_high[i];
                address_entry_valid[i] <= next_address_entry_valid[i];
            end
        end
    end

    // =========================================
    // Outputs
    assign mgmt_rdata_out = rdata;
    assign mgmt_rdata_valid_out = rdata_valid;
    assign wake_event_out = wake_event;
    assign filter_enable_out = wake_filter_enable;

endmodule

`default_nettype wire

// file: tb/wfc_mgmt_host.sv
// Management host model: pointer and data cycles toward the wake bank.
// Assumes requests are one-cycle pulses taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module wfc_mgmt_host (
    // Clock
    input wire logic ref_clk_in,
    // Request toward the bank
    output var wfc_pkg::wfc_mgmt_req_t mgmt_req_out
);
    import wfc_pkg::*;
    int gap = 0;
    initial mgmt_req_out = '0;
    // ==========================================
    // Bus cycles
    // Idle fields are inverted so sampling them off-strobe shows up
    task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d);
        repeat (gap) @(posedge ref_clk_in);
        @(posedge ref_clk_in);
        mgmt_req_out <= '{wr: w, rd: !w, regaddr: a, wdata: d};
        @(posedge ref_clk_in);
        mgmt_req_out <= '{wr: 1'b0, rd: 1'b0, regaddr: ~a, wdata: ~d};
    endtask
    task automatic write_reg(input logic [15:0] idx, input logic [15:0] d);
        access(1'b1, WFC_MGMT_ADDR_SET, idx);
        access(1'b1, WFC_MGMT_DATA, d);
    endtask
    task automatic read_reg(input logic [15:0] idx);
        access(1'b1, WFC_MGMT_ADDR_SET, idx);
        access(1'b0, WFC_MGMT_DATA, ~idx);
    endtask
endmodule
`default_nettype wire

// file: tb/wfc_wake_regs_checker.sv
// Port-level checker for the wake register bank.
// Assumes one clock and synchronous active-high resets; attached by bind.
`timescale 1ns/1ps
`default_nettype none
module wfc_wake_regs_checker (
    // Clock and resets
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic por_rst_in,
    // Watched ports
    input wire wfc_pkg::wfc_mgmt_req_t mgmt_req_in,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic mgmt_rdata_valid_out,
    input wire wfc_pkg::wfc_pkt_t pkt_in,
    input wire logic wake_event_out,
    input wire logic [15:0] filter_enable_out
);
    import wfc_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in || por_rst_in);
    // ==========================================
    // Properties
    property p_rd_answer; mgmt_req_in.rd |=> mgmt_rdata_valid_out; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_valid_pulse; !mgmt_req_in.rd |=> !mgmt_rdata_valid_out; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("read valid without read");
    property p_rdata_hold; !mgmt_req_in.rd |=> $stable(mgmt_rdata_out); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_wake_cause; !pkt_in.valid |=> !wake_event_out; endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without packet");
    // Status bits 8,9 pair with enables 9,10; bits 10,11 live in wake control and are left out
    property p_wake_hit; pkt_in.valid && !(pkt_in.mgmt_pass && filter_enable_out[11]) &&
        |({pkt_in.hits[15:12], pkt_in.hits[9:8], pkt_in.hits[7:0]} &
        {filter_enable_out[15:12], filter_enable_out[10:9], filter_enable_out[7:0]}) |=> wake_event_out; endproperty
    a_wake_hit: assert property (p_wake_hit) else $error("enabled hit gave no wake");
    property p_ignore; pkt_in.valid && pkt_in.mgmt_pass && filter_enable_out[11] |=> !wake_event_out; endproperty
    a_ignore: assert property (p_ignore) else $error("manageability packet woke host");
    property p_reserved; filter_enable_out[WFC_EN_RESERVED] == 1'b0; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved enable bit set");
    property p_en_reset; disable iff (sys_rst_in) por_rst_in |=> filter_enable_out == 16'h0000; endproperty
    a_en_reset: assert property (p_en_reset) else $error("enables not cleared");
endmodule
bind wfc_wake_regs wfc_wake_regs_checker u_chk (.ref_clk_in, .sys_rst_in, .por_rst_in, .mgmt_req_in,
    .mgmt_rdata_out, .mgmt_rdata_valid_out, .pkt_in, .wake_event_out, .filter_enable_out);
`default_nettype wire

// file: tb/wfc_wake_regs_tb.sv
// Self-checking bench for the wake register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module wfc_wake_regs_tb;
    import wfc_pkg::*;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic por_rst_in = 1'b1;
    wfc_mgmt_req_t mgmt_req;
    wfc_pkt_t pkt = '0;
    wfc_nvm_word_t nvm = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic wake;
    logic [15:0] fen;
    logic [15:0] exp_q[$];
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    always #20 ref_clk_in = ~ref_clk_in;
    wfc_mgmt_host host (.ref_clk_in(ref_clk_in), .mgmt_req_out(mgmt_req));
    wfc_wake_regs dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .por_rst_in(por_rst_in),
        .mgmt_req_in(mgmt_req), .mgmt_rdata_out(rdata), .mgmt_rdata_valid_out(rvalid), .pkt_in(pkt),
        .nvm_in(nvm), .wake_event_out(wake), .filter_enable_out(fen));
    // ==========================================
    // Checking and closing
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Each read answer consumes the oldest expectation; sampled mid-cycle, clear of the launching edge
    always @(negedge ref_clk_in) begin
        if (rvalid === 1'b1) begin
            check("read data", (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx, rdata);
        end
    end
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // ==========================================
    // Stimulus
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        exp_q.push_back(exp);
        host.read_reg(idx);
    endtask
    task automatic send(input logic [15:0] h, input logic mp, input logic mc, input logic [47:0] da, input logic ew);
        @(posedge ref_clk_in);
        pkt <= '{valid: 1'b1, mgmt_pass: mp, mcast_hash_hit: mc, hits: h, dest_addr: da};
        @(posedge ref_clk_in);
        pkt <= '{valid: 1'b0, mgmt_pass: ~mp, mcast_hash_hit: ~mc, hits: ~h, dest_addr: ~da};
        @(negedge ref_clk_in);
        check("wake", 16'(ew), 16'(wake));
        @(posedge ref_clk_in);
    endtask
    task automatic nvm_word(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        nvm <= '{valid: 1'b1, word_addr: a, data: d};
        @(posedge ref_clk_in);
        nvm <= '{valid: 1'b0, word_addr: ~a, data: ~d};
    endtask
    initial begin
        logic [15:0] en;
        logic [15:0] h;
        logic [15:0] q;
        logic [15:0] w;
        logic [31:0] lo;
        logic [15:0] hi;
        logic mp;
        logic mc;
        void'($urandom(98811));
        repeat (12) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        por_rst_in <= 1'b0;
        rd(WFC_IDX_FILTER_EN, 16'h0000);
        rd(WFC_IDX_STATUS, 16'h0000);
        rd(WFC_IDX_ADDR_BASE, 16'h0000);
        host.write_reg(WFC_IDX_FILTER_EN, 16'hFFFF);
        rd(WFC_IDX_FILTER_EN, 16'hFEFF);
        @(negedge ref_clk_in);
        check("enable port", 16'hFEFF, fen);
        $display("test reset and enable done");
        host.write_reg(WFC_IDX_WAKE_CTRL, 16'hC000);
        for (int i = 0; i < 24; i++) begin
            host.gap = (i >= 12) ? 2 : 0;
            en = 16'($urandom()) & 16'hFEFF;
            h = 16'($urandom());
            mp = 1'($urandom());
            mc = 1'($urandom());
            host.write_reg(WFC_IDX_FILTER_EN, en);
            host.write_reg(WFC_IDX_STATUS, 16'hFFFF);
            q = (h | {12'h000, mc, 3'h0}) & {en[15:12], 2'h3, en[10:9], en[7:0]};
            q = (mp && en[11]) ? 16'h0000 : q;
            send(h, mp, mc, {16'($urandom()), 32'($urandom())}, |q);
            rd(WFC_IDX_STATUS, q);
            rd(WFC_IDX_WAKE_CTRL, 16'hC000 | {13'h0000, |q, 2'h0});
            w = 16'($urandom());
            host.write_reg(WFC_IDX_STATUS, w);
            rd(WFC_IDX_STATUS, q & ~w);
            host.write_reg(WFC_IDX_WAKE_CTRL, 16'hC004);
        end
        host.gap = 0;
        $display("test random filters done");
        lo = $urandom();
        hi = 16'($urandom());
        host.write_reg(WFC_IDX_ADDR_BASE + 16'h0018, lo[15:0]);
        host.write_reg(WFC_IDX_ADDR_BASE + 16'h0019, lo[31:16]);
        host.write_reg(WFC_IDX_ADDR_BASE + 16'h001A, hi);
        host.write_reg(WFC_IDX_FILTER_EN, 16'h0004);
        host.write_reg(WFC_IDX_STATUS, 16'hFFFF);
        rd(WFC_IDX_ADDR_BASE + 16'h0019, lo[31:16]);
        send(16'h0000, 1'b0, 1'b0, {hi, lo}, 1'b0);
        host.write_reg(WFC_IDX_ADDR_BASE + 16'h001B, 16'h8000);
        send(16'h0000, 1'b0, 1'b0, {hi, lo}, 1'b1);
        rd(WFC_IDX_STATUS, 16'h0004);
        lo = $urandom();
        nvm_word(2'h0, lo[15:0]);
        nvm_word(2'h1, lo[31:16]);
        rd(WFC_IDX_ADDR_BASE, lo[15:0]);
        rd(WFC_IDX_ADDR_BASE + 16'h0001, lo[31:16]);
        $display("test exact address done");
        host.write_reg(WFC_IDX_FILTER_EN, 16'h0001);
        send(16'h0001, 1'b0, 1'b0, 48'h0000_0000_0000, 1'b1);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd(WFC_IDX_STATUS, 16'h0005);
        rd(WFC_IDX_FILTER_EN, 16'h0001);
        por_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        por_rst_in <= 1'b0;
        rd(WFC_IDX_STATUS, 16'h0000);
        rd(WFC_IDX_FILTER_EN, 16'h0000);
        repeat (4) @(posedge ref_clk_in);
        check("pending reads", 16'h0000, 16'(exp_q.size()));
        $display("test resets done");
        give_verdict();
    end
endmodule
`default_nettype wire
